// ===== rtl/mac_filter_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MAC_FILTER_REGS_SVH
`define MAC_FILTER_REGS_SVH
`define OFS_STATION_ADDR_UPPER 12'h0_000
`define OFS_HASH_LOW 12'h0_004
`define OFS_HASH_HIGH 12'h0_008
`define OFS_BACKOFF_OBSERVE 12'h0_00C
`define OFS_PACING_OBSERVE 12'h0_010
`define RST_STATION_ADDR 32'h0000_0000
`define RST_HASH 32'h0000_0000
`define RND_LSB 16
`define TALLY_LSB 12
`define PACE_LOAD 5'h1F
`define IPG_NS 96
`define SLOT_NS 512
`define IPG_CYCLES ((`IPG_NS + 7) / 8)
`define SLOT_CYCLES ((`SLOT_NS + 7) / 8)
`endif

// ===== rtl/mac_filter_pkg.sv
// Types shared by the filter, back-off and pacing block
package mac_filter_pkg;
  // Transmit gap states
  typedef enum logic [2:0] {
    GAP_IDLE = 3'b001,
    GAP_WAIT = 3'b010,
    GAP_BACKOFF = 3'b100
  } gap_state_t;
  // Transmit frame end report
  typedef struct packed {
    logic done;
    logic collided;
    logic deferred;
  } tx_report_t;
  // Received destination address
  typedef struct packed {
    logic valid;
    logic [47:0] addr;
  } rx_addr_t;
endpackage

// ===== rtl/group_hash_fold.sv
// XOR fold of a destination address into a 6-bit hash
`timescale 1ns/10ps
module group_hash_fold (
  input wire logic [47:0] destination_address,
  output logic [5:0] hash
);
  // One fold per hash bit
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_fold
      assign hash[i] = destination_address[i] ^ destination_address[i+6]
        ^ destination_address[i+12] ^ destination_address[i+18]
        ^ destination_address[i+24] ^ destination_address[i+30]
        ^ destination_address[i+36] ^ destination_address[i+42];
    end
  endgenerate
endmodule // group_hash_fold

// ===== rtl/mac_hash_filter_backoff_pacing.sv
// Station address, group hash filter, back-off and transmit pacing
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "mac_filter_regs.svh"
module mac_hash_filter_backoff_pacing #(
  parameter int IPG_CYCLES = `IPG_CYCLES,
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mac_filter_pkg::rx_addr_t rx_dest,
  output logic rx_group_accept,
  output logic rx_group_valid,
  input wire mac_filter_pkg::tx_report_t tx_report,
  input wire logic tx_collision,
  input wire logic tx_frame_start,
  output logic tx_gap_ok,
  output logic [47:0] station_source_address
);
  // Register storage
  logic [31:0] station_addr_upper_bytes_r;
  logic [31:0] group_hash_table_low_r;
  logic [31:0] group_hash_table_high_r;
  // Back-off and pacing state
  logic [9:0] backoff_random_value_r;
  logic [3:0] frame_collision_tally_r;
  logic [9:0] slot_wait_counter_r;
  logic [4:0] pacing_counter_value_r;
  // Slot and gap timing
  logic [15:0] slot_tick_r;
  logic [15:0] gap_count_r;
  logic last_clean_r;
  mac_filter_pkg::gap_state_t gap_state_r;
  // Combinational helpers
  logic [5:0] hash;
  logic [63:0] table_full;
  logic setup_w;
  logic access_w;
  logic [31:0] rd_nxt;
  logic hit_w;
  logic [9:0] mask_w;
  logic [15:0] gap_len_w;

  // Bus phases
  // Access phase covers the cycle that carries ready
  assign setup_w = psel && !penable;
  assign access_w = psel && penable;

  // Hash of received address
  // Table bit index is the folded hash
  group_hash_fold u_fold (
    .destination_address(rx_dest.addr),
    .hash(hash)
  );
  assign table_full = {group_hash_table_high_r, group_hash_table_low_r};
  assign hit_w = (rx_dest.addr[0]) && table_full[hash];

  // Read mux and address decode
  // Reserved bits read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      // Writable registers read back as stored
      `OFS_STATION_ADDR_UPPER: rd_nxt = station_addr_upper_bytes_r;
      `OFS_HASH_LOW: rd_nxt = group_hash_table_low_r;
      `OFS_HASH_HIGH: rd_nxt = group_hash_table_high_r;
      // Observe word: random value, tally, back-off count
      `OFS_BACKOFF_OBSERVE: begin
        rd_nxt[`RND_LSB +: 10] = backoff_random_value_r;
        rd_nxt[`TALLY_LSB +: 4] = frame_collision_tally_r;
        rd_nxt[9:0] = slot_wait_counter_r;
      end
      // Pacing value, nonzero while pacing is active
      `OFS_PACING_OBSERVE: rd_nxt[4:0] = pacing_counter_value_r;
      // Unmapped offsets read as zero
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // APB answer: no wait state, ready in the first access cycle
  // Ready is a one-cycle pulse; a held access phase gets no second one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Bus answer idle in reset
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Ready follows every setup cycle
      pready <= setup_w;
      if (setup_w) begin
        // Read data captured at setup, write cycles return zero
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        // Error for any offset outside the five registers
        pslverr <= !(paddr == `OFS_STATION_ADDR_UPPER || paddr == `OFS_HASH_LOW ||
                     paddr == `OFS_HASH_HIGH || paddr == `OFS_BACKOFF_OBSERVE ||
                     paddr == `OFS_PACING_OBSERVE);
      end else begin
        // Error stands only with its ready pulse
        pslverr <= pslverr && access_w && !pready;
      end
    end
  end

  // Writable registers, written at access completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_addr_upper_bytes_r <= `RST_STATION_ADDR;
      group_hash_table_low_r <= `RST_HASH;
      group_hash_table_high_r <= `RST_HASH;
    end else if (access_w && pready && pwrite) begin
      // Write lands at the access edge that sees ready
      case (paddr)
        `OFS_STATION_ADDR_UPPER: station_addr_upper_bytes_r <= pwdata;
        `OFS_HASH_LOW: group_hash_table_low_r <= pwdata;
        `OFS_HASH_HIGH: group_hash_table_high_r <= pwdata;
        // Observe registers ignore writes without error
        default: ;
      endcase
    end
  end

  // Upper address bytes placed in frame order, low bytes left to others
  // Extra stage keeps the port a flip-flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_source_address <= 48'h0000_0000_0000;
    end else begin
      station_source_address[23:16] <= station_addr_upper_bytes_r[31:24];
      station_source_address[31:24] <= station_addr_upper_bytes_r[23:16];
      station_source_address[39:32] <= station_addr_upper_bytes_r[15:8];
      station_source_address[47:40] <= station_addr_upper_bytes_r[7:0];
      // Lower two bytes belong to another register
      station_source_address[15:0] <= 16'h0000;
    end
  end

  // Receive filter result, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_group_accept <= 1'b0;
      rx_group_valid <= 1'b0;
    end else begin
      // Result qualifier only for group addresses
      rx_group_valid <= rx_dest.valid && rx_dest.addr[0];
      // Accept needs the group bit and a table hit
      rx_group_accept <= rx_dest.valid && hit_w;
    end
  end

  // Free-running random generator, counts from zero
  // Wraps at ten bits and never stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backoff_random_value_r <= 10'h000;
    end else begin
      backoff_random_value_r <= backoff_random_value_r + 10'h001;
    end
  end

  // Per-frame collision tally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_collision_tally_r <= 4'h0;
    end else if (tx_frame_start && !tx_collision) begin
      // New frame clears the count unless it collides at once
      frame_collision_tally_r <= 4'h0;
    end else if (tx_collision && frame_collision_tally_r != 4'hF) begin
      // Count saturates at fifteen
      frame_collision_tally_r <= frame_collision_tally_r + 4'h1;
    end else if (tx_report.done && !tx_report.collided) begin
      // Clean frame end also clears
      frame_collision_tally_r <= 4'h0;
    end
  end

  // Truncated exponential range mask, up to ten bits
  // Range grows one bit per earlier collision
  always_comb begin
    mask_w = 10'h000;
    for (int k = 0; k < 10; k++) begin
      if (k <= int'(frame_collision_tally_r)) mask_w[k] = 1'b1;
    end
  end

  // Slot time tick source
  // A collision restarts slot timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_tick_r <= 16'h0000;
    end else if (tx_collision || slot_tick_r == 16'(SLOT_CYCLES - 1)) begin
      slot_tick_r <= 16'h0000;
    end else begin
      slot_tick_r <= slot_tick_r + 16'h0001;
    end
  end

  // Back-off counter: loaded on collision, one less each slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_wait_counter_r <= 10'h000;
    end else if (tx_collision) begin
      // Random value cut to the allowed range
      slot_wait_counter_r <= backoff_random_value_r & mask_w;
    end else if (slot_wait_counter_r != 10'h000 &&
                 slot_tick_r == 16'(SLOT_CYCLES - 1)) begin
      // One less per slot, held at zero
      slot_wait_counter_r <= slot_wait_counter_r - 10'h001;
    end
  end

  // Pacing counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pacing_counter_value_r <= 5'h00;
    end else if (tx_report.done) begin
      // Only frame ends move the pacing counter
      if (tx_report.collided || tx_report.deferred) begin
        pacing_counter_value_r <= `PACE_LOAD;
      end else if (pacing_counter_value_r != 5'h00) begin
        // Clean frame: one less, never below zero
        pacing_counter_value_r <= pacing_counter_value_r - 5'h01;
      end
    end
  end

  // Gap length: four gaps only after a clean frame while pacing
  // Pacing value after this frame's update decides
  assign gap_len_w = (last_clean_r && pacing_counter_value_r != 5'h00) ?
    16'(4 * IPG_CYCLES) : 16'(IPG_CYCLES);

  // Gap and back-off wait machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_state_r <= mac_filter_pkg::GAP_IDLE;
      gap_count_r <= 16'h0000;
      last_clean_r <= 1'b0;
      tx_gap_ok <= 1'b0;
    end else begin
      case (gap_state_r)
        mac_filter_pkg::GAP_IDLE: begin
          // Gap stays open between frames except at a start
          tx_gap_ok <= !tx_frame_start;
          if (tx_collision) begin
            // Collision: wait out the back-off first
            gap_state_r <= mac_filter_pkg::GAP_BACKOFF;
            tx_gap_ok <= 1'b0;
          end else if (tx_report.done) begin
            // Frame end opens a gap
            last_clean_r <= !(tx_report.collided || tx_report.deferred);
            gap_count_r <= 16'h0000;
            gap_state_r <= mac_filter_pkg::GAP_WAIT;
            tx_gap_ok <= 1'b0;
          end
        end
        mac_filter_pkg::GAP_WAIT: begin
          if (tx_report.done) begin
            // A frame end inside the gap starts a fresh gap
            last_clean_r <= !(tx_report.collided || tx_report.deferred);
            gap_count_r <= 16'h0000;
            tx_gap_ok <= 1'b0;
          end else begin
            // Count cycles until the gap length is reached
            gap_count_r <= gap_count_r + 16'h0001;
            if (gap_count_r + 16'h0001 >= gap_len_w) begin
              gap_state_r <= mac_filter_pkg::GAP_IDLE;
              tx_gap_ok <= 1'b1;
            end
          end
        end
        mac_filter_pkg::GAP_BACKOFF: begin
          // Back-off over: normal gap follows
          if (slot_wait_counter_r == 10'h000 && !tx_collision) begin
            gap_count_r <= 16'h0000;
            last_clean_r <= 1'b0;
            gap_state_r <= mac_filter_pkg::GAP_WAIT;
          end
        end
        default: gap_state_r <= mac_filter_pkg::GAP_IDLE;
      endcase
    end
  end
endmodule // mac_hash_filter_backoff_pacing

// ===== tb/mac_filter_properties.sv
// Port checker for the filter, back-off and pacing block
`timescale 1ns/10ps
module mac_filter_checker #(
  parameter int IPG_CYCLES = 12,
  parameter int SLOT_CYCLES = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mac_filter_pkg::rx_addr_t rx_dest,
  input wire logic rx_group_accept,
  input wire logic rx_group_valid,
  input wire mac_filter_pkg::tx_report_t tx_report,
  input wire logic tx_collision,
  input wire logic tx_frame_start,
  input wire logic tx_gap_ok,
  input wire logic [47:0] station_source_address
);
  logic done_rd; // Completed read
  logic wr_up; // Completed write to the upper address bytes
  assign done_rd = psel && penable && pready && !pwrite;
  assign wr_up = psel && penable && pready && pwrite && paddr == 12'h0_000;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unm; done_rd && paddr > 12'h0_010 |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
  property p_sa; wr_up |=> ##1 station_source_address == {$past(pwdata[7:0], 2),
    $past(pwdata[15:8], 2), $past(pwdata[23:16], 2), $past(pwdata[31:24], 2),
    16'h0000}; endproperty
  a_sa: assert property (p_sa) else $error("source address byte order");
  property p_hold; $changed(station_source_address) |-> $past(wr_up, 2); endproperty
  a_hold: assert property (p_hold) else $error("source address moved alone");
  property p_acc; rx_group_accept |-> rx_group_valid; endproperty
  a_acc: assert property (p_acc) else $error("accept without group result");
  property p_grp; rx_dest.valid && rx_dest.addr[0] |=> rx_group_valid; endproperty
  a_grp: assert property (p_grp) else $error("group address not looked up");
  property p_ind; rx_dest.valid && !rx_dest.addr[0] |=> !rx_group_valid; endproperty
  a_ind: assert property (p_ind) else $error("individual address hashed");
  property p_gap; tx_report.done |=> ##1 !tx_gap_ok [*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap shorter than minimum");
endmodule // mac_filter_checker
bind mac_hash_filter_backoff_pacing mac_filter_checker #(.IPG_CYCLES(IPG_CYCLES),
  .SLOT_CYCLES(SLOT_CYCLES)) chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rx_dest, .rx_group_accept, .rx_group_valid,
  .tx_report, .tx_collision, .tx_frame_start, .tx_gap_ok, .station_source_address);

// ===== tb/phy_model.sv
// Far-side model: frame reports, collisions and received addresses
`timescale 1ns/10ps
module phy_model (
  input wire logic pclk,
  input wire logic tx_gap_ok,
  output mac_filter_pkg::tx_report_t tx_report,
  output logic tx_collision,
  output logic tx_frame_start,
  output mac_filter_pkg::rx_addr_t rx_dest
);
  // Quiet lines at time zero
  initial {tx_report, tx_collision, tx_frame_start, rx_dest} = '0;
  // New frame only once the gap is open
  task automatic start;
    do @(posedge pclk); while (tx_gap_ok !== 1'b1);
    tx_frame_start <= 1'b1;
    @(posedge pclk) tx_frame_start <= 1'b0;
  endtask
  // One collision pulse
  task automatic coll;
    @(posedge pclk) tx_collision <= 1'b1;
    @(posedge pclk) tx_collision <= 1'b0;
  endtask
  // Frame end report, then cycles until the gap opens
  task automatic finish(input logic c, input logic d, output int gap);
    @(posedge pclk) tx_report <= {1'b1, c, d};
    @(posedge pclk) tx_report <= '0;
    // The edge that takes the report still shows the open gap, so step first
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (tx_gap_ok !== 1'b1 && gap < 900);
  endtask
  // Address pulse; the idle address is scrambled, not held
  task automatic rx(input logic [47:0] a);
    @(posedge pclk) rx_dest <= {1'b1, a};
    @(posedge pclk) rx_dest <= {1'b0, ~a};
  endtask
endmodule // phy_model

// ===== tb/tb.sv
// Self-checking bench for the filter, back-off and pacing block
`timescale 1ns/10ps
`include "mac_filter_regs.svh"
module tb;
  localparam int INTER_PACKET_GAP = 4; // Shortened gap
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_collision, tx_frame_start;
  logic rx_group_accept, rx_group_valid, tx_gap_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, w;
  logic [47:0] station_source_address, a;
  logic [63:0] tbl; // Hash table image
  mac_filter_pkg::rx_addr_t rx_dest;
  mac_filter_pkg::tx_report_t tx_report;
  logic [64:0] rq[$]; // Read notes: error, mask, data
  logic aq[$]; // Filter notes
  int seed = 957, mismatches = 0, n_tests = 0, g0, g1, i;
  mac_hash_filter_backoff_pacing #(.IPG_CYCLES(INTER_PACKET_GAP), .SLOT_CYCLES(4)) DUT (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_dest,
    .rx_group_accept, .rx_group_valid, .tx_report, .tx_collision, .tx_frame_start,
    .tx_gap_ok, .station_source_address);
  phy_model phy (.pclk, .tx_gap_ok, .tx_report, .tx_collision, .tx_frame_start, .rx_dest);
  // 125 MHz clock
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready
  task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e, m, input logic er = 0);
    rq.push_back({er, m, e & m});
    xfer(0, ad, 32'h0000_0000);
  endtask
  // Read results against the oldest note
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    v = prdata;
    chk({pslverr, prdata & rq[0][63:32]}, {rq[0][64], rq[0][31:0]});
    void'(rq.pop_front());
  end
  // Filter results against the oldest note
  always @(posedge pclk) if (rx_group_valid === 1'b1) chk(rx_group_accept, aq.pop_front());
  function automatic logic [5:0] fold(input logic [47:0] d);
    fold = '0;
    for (int k = 0; k < 48; k++) fold[k % 6] ^= d[k];
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    #100us;
    mismatches++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++) rd(4 * i, 0, i == 3 ? 32'hFC00_FFFF : '1);
    xfer(1, `OFS_PACING_OBSERVE, '1);
    rd(`OFS_PACING_OBSERVE, 0, '1);
    rd(12'h0_020, 0, '1, 1'b1);
    w = $random(seed);
    xfer(1, `OFS_STATION_ADDR_UPPER, w);
    rd(`OFS_STATION_ADDR_UPPER, w, '1);
    chk(station_source_address, {w[7:0], w[15:8], w[23:16], w[31:24], 16'h0000});
    rd(`OFS_BACKOFF_OBSERVE, 0, 0);
    @(posedge pclk);
    rd(`OFS_BACKOFF_OBSERVE, v + 32'h0004_0000, 32'h03FF_0000);
    $display("registers done");
    tbl = {$random(seed), $random(seed)};
    xfer(1, `OFS_HASH_LOW, tbl[31:0]);
    xfer(1, `OFS_HASH_HIGH, tbl[63:32]);
    rd(`OFS_HASH_LOW, tbl[31:0], '1);
    rd(`OFS_HASH_HIGH, tbl[63:32], '1);
    for (i = 0; i < 60; i++) begin
      a = {$random(seed), $random(seed)};
      if (a[0]) aq.push_back(tbl[fold(a)]);
      phy.rx(a);
    end
    $display("filter done");
    phy.start();
    phy.finish(0, 0, g0);
    chk(g0, INTER_PACKET_GAP + 1);
    phy.start();
    phy.coll();
    rd(`OFS_BACKOFF_OBSERVE, 32'h0000_1000, 32'hFC00_FFFE);
    phy.finish(1, 0, g1);
    rd(`OFS_PACING_OBSERVE, 32'h0000_001F, '1);
    phy.start();
    phy.finish(0, 0, g1);
    chk(g1 - g0, 3 * INTER_PACKET_GAP);
    rd(`OFS_PACING_OBSERVE, 32'h0000_001E, '1);
    phy.start();
    phy.finish(0, 1, g1);
    chk(g1, g0);
    rd(`OFS_PACING_OBSERVE, 32'h0000_001F, '1);
    for (i = 0; i < 32; i++) begin
      phy.start();
      phy.finish(0, 0, g1);
    end
    chk(g1, g0);
    rd(`OFS_PACING_OBSERVE, 0, '1);
    $display("pacing done");
    give_verdict;
  end
endmodule // tb
